// ---- verilog/eth_desc_pkg.sv ----
package eth_desc_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TXDESC = 8'h04;
	localparam logic [7:0] ADDR_TXLEN = 8'h08;
	localparam logic [7:0] ADDR_TXSTAT = 8'h0c;
	localparam logic [7:0] ADDR_RXSTAT = 8'h10;
	localparam logic [7:0] ADDR_NATINFO = 8'h14;
	// control register fields
	localparam int CTL_ACCEPT_OVERSIZE = 0;
	localparam int CTL_GOOD_RX_IRQ = 1;
	localparam int CTL_TX_RUN = 2;
	localparam int CTL_SPEED10 = 3;
	localparam int CTL_XLATE_EN = 4;
	localparam int CTL_INSIDE_PORT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// descriptor fields
	localparam int OWNER_BIT = 31;
	localparam int TXD_IRQ = 2;
	localparam int TXD_CRC = 1;
	localparam int TXD_PAD = 0;
	// transmit status word fields
	localparam int TS_IRQ = 16;
	localparam int TS_WAITED = 17;
	localparam int TS_DONE = 19;
	localparam int TS_EXCESS = 20;
	localparam int TS_NOCRS = 21;
	localparam int TS_ABORT = 22;
	localparam int TS_LATE = 23;
	localparam int TS_STOP = 24;
	localparam int TS_HOLD = 25;
	localparam int TS_HEART = 26;
	localparam int TS_TALLY = 28;
	// receive status word fields
	localparam int RS_IRQ = 16;
	localparam int RS_CSUM = 17;
	localparam int RS_LONG = 19;
	localparam int RS_GOOD = 20;
	// translation information fields
	localparam int NI_HIT = 0;
	localparam int NI_INSIDE = 1;
	localparam int NI_TCP = 2;
	localparam int NI_UDP = 3;
	localparam int NI_SKIPCS = 4;
	localparam int NI_PPPOE = 5;
	localparam int NI_SHORT = 6;
	localparam int NI_ENTRY = 8;
	localparam int NI_HDROFS = 16;
	localparam int NI_NOMATCH = 20;
	localparam int NI_PROTOERR = 21;
	localparam int NI_CSUMERR = 22;
	localparam int NI_FLAGS = 24;
	// frame figures
	localparam logic [15:0] MAX_FRAME = 16'd1518;
	localparam logic [15:0] MIN_PADDED = 16'd60;
	localparam logic [15:0] CRC_BYTES = 16'd4;
	localparam logic [15:0] LATE_BYTES = 16'd64;
	localparam logic [3:0] TALLY_MAX = 4'hf;
	// timing, clock 40 MHz
	localparam longint CLK_PS = 25000;
	localparam longint DEFER100_PS = 327680000;
	localparam longint DEFER10_PS = 3276800000;
	localparam longint HEART_PS = 1600000;
	localparam int DEFER100_CYC = int'(DEFER100_PS / CLK_PS);
	localparam int DEFER10_CYC = int'(DEFER10_PS / CLK_PS);
	localparam int HEART_CYC = int'(HEART_PS / CLK_PS);
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_DEFER = 3'b001,
		TX_SEND = 3'b010,
		TX_BACKOFF = 3'b011,
		TX_HEART = 3'b100,
		TX_FINISH = 3'b101,
		TX_RELEASE = 3'b110
	} tx_state_e;
endpackage : eth_desc_pkg

// ---- verilog/eth_mac_desc_status.sv ----
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module eth_mac_desc_status #(
	parameter int DEFER_LIMIT_100 = eth_desc_pkg::DEFER100_CYC,
	parameter int DEFER_LIMIT_10 = eth_desc_pkg::DEFER10_CYC
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TX_CLK,
	input wire logic CRS,
	input wire logic COL,
	input wire logic RX_DV,
	input wire logic RX_ER,
	output logic TX_EN,
	input wire logic PAUSE_REQ,
	input wire logic RX_FRAME_END,
	input wire logic [15:0] RX_FRAME_LEN,
	input wire logic RX_FCS_BAD,
	input wire logic PARSE_HIT,
	input wire logic PARSE_TCP,
	input wire logic PARSE_UDP,
	input wire logic PARSE_CSUM_ZERO,
	input wire logic PARSE_SHORT_PROTO,
	input wire logic PARSE_PPPOE,
	input wire logic [5:0] PARSE_TCP_FLAGS,
	input wire logic [3:0] PARSE_HDR_OFS,
	input wire logic [3:0] PARSE_ENTRY
);
	import eth_desc_pkg::*;

	// pin synchronisers: three stages, a change counts once stages two and three agree
	logic [4:0] pin_raw;
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic [4:0] sync3_r;
	logic [4:0] pin_r;
	assign pin_raw = {RX_ER, RX_DV, COL, CRS, TX_CLK};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge CLK or negedge NRST) begin
				if (!NRST) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
					pin_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= pin_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					if (sync2_r[gi] == sync3_r[gi]) begin
						pin_r[gi] <= sync3_r[gi];
					end
				end
			end
		end
	endgenerate

	logic tclk_s, crs_s, col_s, rxdv_s, rxer_s;
	assign {rxer_s, rxdv_s, col_s, crs_s, tclk_s} = pin_r;

	// apb decode, used for both the write enable and the unmapped answer
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == ADDR_CTRL) || (a == ADDR_TXDESC) || (a == ADDR_TXLEN) ||
			(a == ADDR_TXSTAT) || (a == ADDR_RXSTAT) || (a == ADDR_NATINFO);
	endfunction : addr_mapped

	logic setup_ph, wr_en;
	assign setup_ph = PSEL && !PENABLE;
	assign wr_en = PSEL && PENABLE && PREADY && PWRITE && addr_mapped(PADDR);

	// control register
	logic [5:0] ctrl_r;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_r <= CTRL_RESET;
		end else if (wr_en && PADDR == ADDR_CTRL) begin
			ctrl_r <= PWDATA[5:0];
		end
	end

	// transmit descriptor state
	tx_state_e tx_state_r;
	logic tx_own_r;
	logic [2:0] tx_enbits_r;
	logic [15:0] tx_len_r;
	logic [31:16] tx_stat_r;
	logic tx_ok_r;
	logic tx_start;
	assign tx_start = (tx_state_r == TX_IDLE) && tx_own_r && ctrl_r[CTL_TX_RUN] && !PAUSE_REQ;

	// ownership: software hands over, device gives back only after success
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tx_own_r <= 1'b0;
			tx_enbits_r <= 3'h0;
		end else if (wr_en && PADDR == ADDR_TXDESC) begin
			tx_own_r <= PWDATA[OWNER_BIT];
			tx_enbits_r <= PWDATA[2:0];
		end else if (tx_state_r == TX_RELEASE && tx_ok_r) begin
			tx_own_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tx_len_r <= 16'h0000;
		end else if (wr_en && PADDR == ADDR_TXLEN) begin
			tx_len_r <= PWDATA[15:0];
		end
	end

	// bytes on the wire: padding lifts short frames, crc adds four
	logic [15:0] padded_len, wire_len;
	always_comb begin
		padded_len = tx_len_r;
		if (tx_enbits_r[TXD_PAD] && tx_len_r < MIN_PADDED) begin
			padded_len = MIN_PADDED;
		end
		wire_len = tx_enbits_r[TXD_CRC] ? padded_len + CRC_BYTES : padded_len;
	end

	// tx clock edge seen through the synchroniser; mii moves a nibble per edge
	logic tclk_prev_r;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tclk_prev_r <= 1'b0;
		end else begin
			tclk_prev_r <= tclk_s;
		end
	end
	logic tclk_rise;
	assign tclk_rise = tclk_s && !tclk_prev_r;

	logic [19:0] defer_cnt_r;
	logic [19:0] defer_lim;
	logic [15:0] byte_cnt_r;
	logic half_r, crs_seen_r, heart_seen_r;
	logic [6:0] heart_cnt_r;
	assign defer_lim = ctrl_r[CTL_SPEED10] ? 20'(DEFER_LIMIT_10) : 20'(DEFER_LIMIT_100);

	// transmit sequencer and its status word
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tx_state_r <= TX_IDLE;
			tx_stat_r <= 16'h0000;
			tx_ok_r <= 1'b0;
			TX_EN <= 1'b0;
			defer_cnt_r <= 20'h00000;
			byte_cnt_r <= 16'h0000;
			half_r <= 1'b0;
			crs_seen_r <= 1'b0;
			heart_seen_r <= 1'b0;
			heart_cnt_r <= 7'h00;
		end else begin
			unique case (tx_state_r)
				TX_IDLE: begin
					if (tx_own_r && !ctrl_r[CTL_TX_RUN]) begin
						tx_stat_r[TS_STOP] <= 1'b1;
					end
					if (tx_own_r && ctrl_r[CTL_TX_RUN] && PAUSE_REQ) begin
						tx_stat_r[TS_HOLD] <= 1'b1;
					end
					if (tx_start) begin
						tx_stat_r <= 16'h0000; // fresh word per frame
						tx_ok_r <= 1'b0;
						defer_cnt_r <= 20'h00000;
						tx_state_r <= TX_DEFER;
					end
				end
				TX_DEFER: begin
					if (crs_s) begin
						tx_stat_r[TS_WAITED] <= 1'b1;
						if (defer_cnt_r >= defer_lim) begin
							tx_stat_r[TS_EXCESS] <= 1'b1;
						end else begin
							defer_cnt_r <= defer_cnt_r + 20'h00001;
						end
					end else begin
						TX_EN <= 1'b1;
						byte_cnt_r <= 16'h0000;
						half_r <= 1'b0;
						crs_seen_r <= 1'b0;
						tx_state_r <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (crs_s) begin
						crs_seen_r <= 1'b1;
					end
					if (col_s) begin
						TX_EN <= 1'b0;
						if (byte_cnt_r >= LATE_BYTES) begin
							tx_stat_r[TS_LATE] <= 1'b1;
							tx_state_r <= TX_FINISH;
						end else if (tx_stat_r[31:28] == TALLY_MAX) begin
							tx_stat_r[31:28] <= TALLY_MAX;
							tx_stat_r[TS_ABORT] <= 1'b1;
							tx_state_r <= TX_FINISH;
						end else begin
							tx_stat_r[31:28] <= tx_stat_r[31:28] + 4'h1;
							tx_state_r <= TX_BACKOFF;
						end
					end else if (byte_cnt_r == wire_len) begin
						TX_EN <= 1'b0;
						tx_stat_r[TS_NOCRS] <= !crs_seen_r;
						heart_cnt_r <= 7'h00;
						heart_seen_r <= 1'b0;
						tx_state_r <= TX_HEART;
					end else if (tclk_rise) begin
						half_r <= !half_r;
						if (half_r) begin
							byte_cnt_r <= byte_cnt_r + 16'h0001;
						end
					end
				end
				TX_BACKOFF: begin
					// retry without refetch once the collision has cleared
					if (!col_s) begin
						defer_cnt_r <= 20'h00000;
						tx_state_r <= TX_DEFER;
					end
				end
				TX_HEART: begin
					if (col_s) begin
						heart_seen_r <= 1'b1;
					end
					if (heart_cnt_r == 7'(HEART_CYC - 1)) begin
						tx_stat_r[TS_HEART] <= !(heart_seen_r || col_s);
						tx_ok_r <= 1'b1;
						tx_state_r <= TX_FINISH;
					end else begin
						heart_cnt_r <= heart_cnt_r + 7'h01;
					end
				end
				TX_FINISH: begin
					tx_stat_r[TS_DONE] <= 1'b1;
					tx_stat_r[TS_IRQ] <= tx_enbits_r[TXD_IRQ];
					tx_state_r <= TX_RELEASE;
				end
				TX_RELEASE: begin
					tx_state_r <= TX_IDLE;
				end
				default: begin
					tx_state_r <= TX_IDLE;
				end
			endcase
		end
	end

	// phy receive error latched across the frame, cleared at its end
	logic rxer_seen_r;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rxer_seen_r <= 1'b0;
		end else if (RX_FRAME_END) begin
			rxer_seen_r <= 1'b0;
		end else if (rxdv_s && rxer_s) begin
			rxer_seen_r <= 1'b1;
		end
	end

	// receive status computed at frame end
	logic rx_long, rx_csum, rx_good;
	assign rx_long = RX_FRAME_LEN > MAX_FRAME && !ctrl_r[CTL_ACCEPT_OVERSIZE];
	assign rx_csum = RX_FCS_BAD || rxer_seen_r || (rxdv_s && rxer_s);
	assign rx_good = !rx_long && !rx_csum;

	logic rx_own_r;
	logic rx_release_r;
	logic [23:16] rx_stat_r;
	logic [15:0] rx_len_r;
	logic rx_take;
	assign rx_take = RX_FRAME_END && rx_own_r && !rx_release_r;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rx_stat_r <= 8'h00;
			rx_len_r <= 16'h0000;
			rx_release_r <= 1'b0;
		end else begin
			rx_release_r <= rx_take && rx_good;
			if (rx_take) begin
				rx_len_r <= RX_FRAME_LEN;
				rx_stat_r <= 8'h00;
				rx_stat_r[RS_LONG] <= rx_long;
				rx_stat_r[RS_CSUM] <= rx_csum;
				rx_stat_r[RS_GOOD] <= rx_good;
				rx_stat_r[RS_IRQ] <= !rx_good || ctrl_r[CTL_GOOD_RX_IRQ];
			end
		end
	end

	// owner returns to software the cycle after the status write-back of a good frame
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rx_own_r <= 1'b0;
		end else if (wr_en && PADDR == ADDR_RXSTAT) begin
			rx_own_r <= PWDATA[OWNER_BIT];
		end else if (rx_release_r) begin
			rx_own_r <= 1'b0;
		end
	end

	// translation information, all zero for frames taken while translation is off
	logic [29:0] nat_r;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			nat_r <= 30'h00000000;
		end else if (rx_take) begin
			nat_r <= 30'h00000000;
			if (ctrl_r[CTL_XLATE_EN]) begin
				nat_r[NI_HIT] <= PARSE_HIT;
				nat_r[NI_INSIDE] <= PARSE_HIT && ctrl_r[CTL_INSIDE_PORT];
				nat_r[NI_TCP] <= PARSE_TCP;
				nat_r[NI_UDP] <= PARSE_UDP;
				nat_r[NI_SKIPCS] <= PARSE_UDP && PARSE_CSUM_ZERO;
				nat_r[NI_PPPOE] <= PARSE_PPPOE;
				nat_r[NI_SHORT] <= PARSE_SHORT_PROTO;
				nat_r[NI_ENTRY +: 4] <= PARSE_HIT ? PARSE_ENTRY : 4'h0;
				nat_r[NI_HDROFS +: 4] <= PARSE_HIT ? PARSE_HDR_OFS : 4'h0;
				nat_r[NI_NOMATCH] <= !PARSE_HIT;
				nat_r[NI_PROTOERR] <= PARSE_TCP && PARSE_UDP;
				nat_r[NI_CSUMERR] <= PARSE_TCP && PARSE_UDP && PARSE_CSUM_ZERO;
				nat_r[NI_FLAGS +: 6] <= (PARSE_HIT && PARSE_TCP) ? PARSE_TCP_FLAGS : 6'h00;
			end
		end
	end

	// read mux
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h00000000;
		unique case (PADDR)
			ADDR_CTRL: rd_val = {26'h0000000, ctrl_r};
			ADDR_TXDESC: rd_val = {tx_own_r, 28'h0000000, tx_enbits_r};
			ADDR_TXLEN: rd_val = {16'h0000, tx_len_r};
			ADDR_TXSTAT: rd_val = {tx_stat_r, 16'h0000};
			ADDR_RXSTAT: rd_val = {rx_own_r, 7'h00, rx_stat_r, rx_len_r};
			ADDR_NATINFO: rd_val = {2'h0, nat_r};
			default: rd_val = 32'h00000000;
		endcase
	end

	// apb answer: ready in the first access cycle, data loaded at setup
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= setup_ph;
			PSLVERR <= setup_ph && !addr_mapped(PADDR);
			if (setup_ph && !PWRITE) begin
				PRDATA <= rd_val;
			end
		end
	end
endmodule : eth_mac_desc_status
`default_nettype wire

// ---- sim/eth_mac_desc_status_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module eth_mac_desc_status_assertions #(
	parameter int DEFER_LIMIT_100 = 20,
	parameter int DEFER_LIMIT_10 = 40
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic CRS,
	input wire logic COL,
	input wire logic TX_EN
);
	wire logic setup = PSEL && !PENABLE;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// zero wait states and a single-cycle ready on every transfer
	AST_READY_AFTER_SETUP: assert property (setup |=> PREADY) else $error("ready missing after setup");
	AST_READY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	AST_READY_CAUSE: assert property (PREADY |-> $past(setup)) else $error("ready without setup");
	AST_ERR_UNMAPPED: assert property (setup && PADDR > 8'h14 |=> PSLVERR) else $error("no error on unmapped");
	AST_ERR_MAPPED: assert property (setup && PADDR <= 8'h14 && PADDR[1:0] == 2'b00 |=> !PSLVERR)
		else $error("error on mapped address");
	// read data moves only on a read setup, so software never sees a torn value
	AST_RDATA_HOLD: assert property (!(setup && !PWRITE) |=> $stable(PRDATA)) else $error("read data moved");
	// six cycles of carrier cover the synchroniser, so no start may follow
	AST_DEFER_CARRIER: assert property (CRS [*6] |=> !$rose(TX_EN)) else $error("start on busy medium");
	AST_COL_STOPS_TX: assert property ($rose(COL) && TX_EN |-> ##[1:8] !TX_EN) else $error("collision ignored");
	// main scenarios reached
	cover property (setup && PADDR > 8'h14);
	cover property ($rose(TX_EN));
	cover property ($rose(COL) && TX_EN);
endmodule : eth_mac_desc_status_assertions
bind eth_mac_desc_status eth_mac_desc_status_assertions #(.DEFER_LIMIT_100(DEFER_LIMIT_100),
	.DEFER_LIMIT_10(DEFER_LIMIT_10)) eth_mac_desc_status_assertions_i (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.CRS(CRS), .COL(COL), .TX_EN(TX_EN));
`default_nettype wire

// ---- sim/eth_phy_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eth_phy_model (
	input wire logic clk,
	input wire logic tx_en,
	input wire logic busy,
	input wire logic echo,
	input wire logic hb,
	input wire logic [1:0] col_mode,
	output logic tx_clk,
	output logic crs,
	output logic col
);
	int on_cnt = 0;
	int off_cnt = 1000;
	int tries = 0;
	logic hit;
	// link clock stands still between frames, phase unrelated to the system clock
	initial begin
		tx_clk = 1'b0;
		#7;
		forever begin
			#100;
			tx_clk = tx_en ? ~tx_clk : 1'b0;
		end
	end
	// wire timing, used to place collisions and the heartbeat
	always @(posedge clk) begin
		on_cnt <= tx_en ? on_cnt + 1 : 0;
		off_cnt <= tx_en ? 0 : off_cnt + 1;
		if (tx_en && on_cnt == 0) tries <= tries + 1;
		else if (off_cnt > 40) tries <= 0; // longer than any retry gap, shorter than the heartbeat wait
	end
	// early hits land at two bytes, late ones beyond the 64 byte slot
	assign hit = (col_mode == 2'd3) ? (on_cnt >= 1060 && on_cnt < 1068)
		: (on_cnt >= 32 && on_cnt < 40 && (col_mode == 2'd2 || (col_mode == 2'd1 && tries == 1)));
	assign col = (tx_en && hit) || (hb && off_cnt >= 16 && off_cnt < 24);
	assign crs = busy || (echo && tx_en);
endmodule : eth_phy_model
`default_nettype wire

// ---- sim/tb_eth_mac_desc_status.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_eth_mac_desc_status;
	logic clk, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pause = 1'b0, busy = 1'b0;
	logic rx_dv = 1'b0, rx_er = 1'b0, rx_end = 1'b0, rx_bad = 1'b0, echo = 1'b1, hb = 1'b1, e;
	logic pslverr, pready, tx_clk, crs, col, tx_en;
	logic [1:0] cm = 2'd0;
	logic [7:0] paddr = 8'h00;
	logic [15:0] rx_len = 16'h0;
	logic [19:0] prs = 20'h0;
	logic [31:0] pwdata = 32'h0, prdata, last_rx, q;
	int error_cnt = 0, num_checks = 0, on_cyc = 0;
	eth_mac_desc_status #(.DEFER_LIMIT_100(20), .DEFER_LIMIT_10(40)) eth_mac_desc_status_i (
		.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_CLK(tx_clk), .CRS(crs), .COL(col),
		.RX_DV(rx_dv), .RX_ER(rx_er), .TX_EN(tx_en), .PAUSE_REQ(pause), .RX_FRAME_END(rx_end),
		.RX_FRAME_LEN(rx_len), .RX_FCS_BAD(rx_bad), .PARSE_HIT(prs[19]), .PARSE_TCP(prs[18]),
		.PARSE_UDP(prs[17]), .PARSE_CSUM_ZERO(prs[16]), .PARSE_SHORT_PROTO(prs[15]), .PARSE_PPPOE(prs[14]),
		.PARSE_TCP_FLAGS(prs[13:8]), .PARSE_HDR_OFS(prs[7:4]), .PARSE_ENTRY(prs[3:0]));
	eth_phy_model eth_phy_model_i (.clk(clk), .tx_en(tx_en), .busy(busy), .echo(echo), .hb(hb),
		.col_mode(cm), .tx_clk(tx_clk), .crs(crs), .col(col));
	// 40 MHz system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// cycles spent driving the wire, gives the frame length seen outside
	always @(posedge clk) if (tx_en) on_cyc <= on_cyc + 1;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one transfer; an idle cycle follows so no signal is driven twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk(q & m, exp & m);
	endtask : rd
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	// translation word built from the classification
	function automatic logic [31:0] nat_exp(input logic [19:0] p, input logic ins);
		logic s;
		s = p[17] & p[16];
		return {2'b00, p[13:8], 1'b0, p[18] & s, p[18] & p[17], ~p[19], p[7:4], 4'h0, p[3:0], 1'b0, p[15],
			p[14], s, p[17], p[18], ins, p[19]};
	endfunction : nat_exp
	task automatic rx(input logic [15:0] len, input logic bad, input logic er, input logic [19:0] p,
		input logic [5:0] ctl, input logic own);
		logic lng, err;
		lng = len > 16'd1518 && !ctl[0];
		err = lng | bad | er;
		apb(1'b1, 8'h00, {26'h0, ctl});
		if (own) apb(1'b1, 8'h10, 32'h80000000);
		rx_dv <= 1'b1;
		rx_er <= er;
		repeat (6) @(posedge clk);
		rx_dv <= 1'b0;
		rx_er <= 1'b0;
		// let the pin synchroniser drain so no stale receive error leaks past the frame end
		repeat (5) @(posedge clk);
		rx_end <= 1'b1;
		rx_len <= len;
		rx_bad <= bad;
		prs <= p;
		@(posedge clk);
		rx_end <= 1'b0;
		repeat (3) @(posedge clk);
		if (own) last_rx = {err, 10'h0, !err, lng, 1'b0, bad | er, err | ctl[1], len};
		rd(8'h10, last_rx, '1);
		rd(8'h14, nat_exp(p, ctl[5]), !own ? 32'h0 : !ctl[4] ? 32'h1 : p[19] ? '1 : 32'h00100001);
	endtask : rx
	// back-to-back status reads: done stands only two cycles when a kept descriptor restarts
	task automatic wait_done();
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= 1'b0;
		paddr <= 8'h0c;
		do begin
			penable <= 1'b0;
			@(posedge clk);
			penable <= 1'b1;
			do @(posedge clk); while (pready !== 1'b1);
			q = prdata;
			n++;
		end while (q[19] !== 1'b1 && n < 2000);
		if (n >= 2000) error_cnt++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : wait_done
	// m holds carrier echo, heartbeat and the owner bit expected afterwards
	task automatic tx(input logic [5:0] ctl, input logic [15:0] len, input logic [2:0] d, input int bz,
		input logic [1:0] c, input logic [2:0] m, input logic [31:0] exp, input logic [31:0] msk, input int wl);
		int n;
		cm <= c;
		echo <= m[2];
		hb <= m[1];
		busy <= bz > 0;
		on_cyc <= 0;
		apb(1'b1, 8'h00, {26'h0, ctl});
		apb(1'b1, 8'h08, {16'h0, len});
		apb(1'b1, 8'h04, {1'b1, 28'h0, d});
		repeat (bz + 2) @(posedge clk);
		busy <= 1'b0;
		wait_done();
		if (c == 2'd2) chk(32'(eth_phy_model_i.tries), 32'd16);
		chk(q & msk, exp & msk);
		if (wl > 0) chk(32'((on_cyc + 8) / 16), 32'(wl));
		rd(8'h04, {m[0], 28'h0, d}, '1);
		cm <= 2'd0;
		n = 0;
		while (q[31] === 1'b1 && n < 3000) begin
			apb(1'b0, 8'h04, 32'h0);
			n++;
		end
		if (n >= 3000) error_cnt++;
	endtask : tx
	// hang guard, far beyond the longest expected run
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 6; a++) rd(8'(a * 4), 32'h0, '1);
		apb(1'b1, 8'h18, 32'hffffffff);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, 8'h00, 32'h3f);
		rd(8'h00, 32'h3f, '1);
		rx(16'd1518, 1'b0, 1'b0, 20'hcaa59, 6'h12, 1'b1);
		rx(16'd1519, 1'b0, 1'b0, 20'hb4023, 6'h30, 1'b1);
		rx(16'd1519, 1'b0, 1'b0, 20'hf3f11, 6'h11, 1'b1);
		rx(16'd77, 1'b0, 1'b0, 20'h0, 6'h10, 1'b0);
		rx(16'd64, 1'b1, 1'b0, 20'h0, 6'h12, 1'b1);
		rx(16'd64, 1'b0, 1'b1, 20'h0, 6'h02, 1'b1);
		tx(6'h04, 16'd10, 3'h7, 0, 2'd0, 3'b110, 32'h00090000, '1, 64);
		tx(6'h04, 16'd10, 3'h0, 0, 2'd0, 3'b110, 32'h00080000, '1, 10);
		tx(6'h04, 16'd10, 3'h2, 0, 2'd0, 3'b100, 32'h04080000, '1, 14);
		tx(6'h04, 16'd60, 3'h0, 0, 2'd0, 3'b010, 32'h00280000, '1, 60);
		tx(6'h04, 16'd10, 3'h1, 60, 2'd0, 3'b110, 32'h001a0000, '1, 60);
		tx(6'h0c, 16'd10, 3'h0, 30, 2'd0, 3'b110, 32'h000a0000, '1, 10);
		tx(6'h04, 16'd10, 3'h0, 0, 2'd1, 3'b100, 32'h10080000, 32'hfbfdffff, 0);
		tx(6'h04, 16'd10, 3'h0, 0, 2'd2, 3'b101, 32'hf0480000, 32'hfbfdffff, 0);
		tx(6'h04, 16'd100, 3'h2, 0, 2'd3, 3'b101, 32'h00880000, 32'h0bfdffff, 0);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h80000000);
		repeat (8) @(posedge clk);
		rd(8'h0c, 32'h01000000, 32'h01000000);
		pause <= 1'b1;
		apb(1'b1, 8'h00, 32'h4);
		repeat (8) @(posedge clk);
		rd(8'h0c, 32'h02000000, 32'h02000000);
		chk({31'h0, tx_en}, 32'h0);
		pause <= 1'b0;
		// the old done bit stands until the start clears the word
		repeat (4) @(posedge clk);
		wait_done();
		chk(q & 32'h00080000, 32'h00080000);
		test_done();
	end
endmodule : tb_eth_mac_desc_status
`default_nettype wire
